// ==== bench/mcu8_instruction_execution_tb.sv ====
/*
  Self-checking bench of the decode and execute core with a program model.
  Assumes the core restarts at address 0 after each reset.
*/
`timescale 1ns/1ps
module mcu8_instruction_execution_tb;
  typedef struct packed {
    logic [95:0] prog;
    logic [3:0]  idx;
    logic [2:0]  gap;
    logic [11:0] pc;
    logic [1:0]  flags;
  } mie_row_t;

  logic        clock;
  logic        reset;
  logic        wdogSel;
  logic        wakeUp;
  logic [95:0] progImage;
  logic [7:0]  progData;
  logic [11:0] progAddr;
  logic        waitMode;
  logic        stopMode;
  logic        instrDone;
  logic        flagZero;
  logic        flagCarry;
  int          nMismatch;
  int          nChecks;

  // ==========================================================
  // Rows: program, done index, cycles, next address, zero and carry
  mie_row_t rows [28] = '{
    '{96'hED80_00F4_E401_E380_EB00_F9F9, 4'h5, 3'h4, 12'h00A, 2'h1},
    '{96'hE4FF_E401_F9F9_F9F9_F9F9_F9F9, 4'h2, 3'h4, 12'h004, 2'h3},
    '{96'hF9E7_01F9_F9F9_F9F9_F9F9_F9F9, 4'h2, 3'h4, 12'h003, 2'h1},
    '{96'hE407_E607_E600_F9F9_F9F9_F9F9, 4'h3, 3'h4, 12'h006, 2'h0},
    '{96'hE4FF_E401_E500_F9F9_F9F9_F9F9, 4'h3, 3'h4, 12'h006, 2'h2},
    '{96'hED7F_00E8_7FE4_FFE0_7FF9_F9F9, 4'h4, 3'h4, 12'h009, 2'h3},
    '{96'hE4FF_E401_ED30_00F9_F9F9_F9F9, 4'h3, 3'h4, 12'h007, 2'h3},
    '{96'hE4FF_E401_EC00_F9F9_F9F9_F9F9, 4'h3, 3'h4, 12'h006, 2'h2},
    '{96'hE4FF_E401_EA00_F9F9_F9F9_F9F9, 4'h3, 3'h4, 12'h006, 2'h1},
    '{96'hED7F_00E8_7FE9_7FF9_F9F9_F9F9, 4'h3, 3'h4, 12'h007, 2'h2},
    '{96'hED80_00ED_8100_F1ED_0100_D4D5, 4'h6, 3'h4, 12'h00C, 2'h2},
    '{96'hE4FF_ED80_00ED_0000_C4C0_F9F9, 4'h5, 3'h4, 12'h00A, 2'h3},
    '{96'hF9EE_EEF9_F9F9_F9F9_F9F9_F9F9, 4'h3, 3'h4, 12'h003, 2'h3},
    '{96'hE480_EFEF_F9F9_F9F9_F9F9_F9F9, 4'h3, 3'h4, 12'h004, 2'h0},
    '{96'hE480_F800_F9F9_F9F9_F9F9_F9F9, 4'h2, 3'h4, 12'h004, 2'h3},
    '{96'hE4FF_E401_03F9_F9F9_F9F9_F9F9, 4'h3, 3'h2, 12'h008, 2'h3},
    '{96'hE4FF_E401_23F9_F9F9_F9F9_F9F9, 4'h3, 3'h2, 12'h005, 2'h3},
    '{96'hE4FF_E401_54F9_F9F9_F9F9_F9F9, 4'h3, 3'h2, 12'h000, 2'h3},
    '{96'hF96F_F9F9_F9F9_F9F9_F9F9_F9F9, 4'h2, 3'h2, 12'h011, 2'h0},
    '{96'hF925_F9F9_F9F9_F9F9_F9F9_F9F9, 4'h2, 3'h2, 12'h007, 2'h0},
    '{96'hF97F_F9F9_F9F9_F9F9_F9F9_F9F9, 4'h2, 3'h2, 12'hFF2, 2'h0},
    '{96'hF98A_BCF9_F9F9_F9F9_F9F9_F9F9, 4'h2, 3'h4, 12'hABC, 2'h0},
    '{96'hF990_05F9_F9FA_F9F9_F9F9_F9F9, 4'h3, 3'h2, 12'h003, 2'h0},
    '{96'hE4FF_E401_9008_F9F9_FBF9_F9F9, 4'h4, 3'h2, 12'h006, 2'h0},
    '{96'hE4FF_E401_ED20_00B7_20F9_F9F9, 4'h4, 3'h4, 12'h009, 2'h3},
    '{96'hED20_00B7_20A7_2005_F9F9_F9F9, 4'h3, 3'h5, 12'h00C, 2'h1},
    '{96'hED20_00B7_20B6_20A6_20F6_F9F9, 4'h4, 3'h5, 12'hFFF, 2'h0},
    '{96'hED20_00B7_20A6_2005_F9F9_F9F9, 4'h3, 3'h5, 12'h008, 2'h1}
  };

  mie_core mie_core_inst (
    .clock(clock), .reset(reset), .progData(progData), .wdogSel(wdogSel), .wakeUp(wakeUp),
    .progAddr(progAddr), .waitMode(waitMode), .stopMode(stopMode), .instrDone(instrDone),
    .flagZero(flagZero), .flagCarry(flagCarry));

  mie_prog_rom mie_prog_rom_inst (.progAddr(progAddr), .progImage(progImage), .progData(progData));

  initial begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    nChecks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finishTest;
    $display("Checks %0d mismatches %0d", nChecks, nMismatch);
    if (nMismatch == 0 && nChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic start(input logic [95:0] img);
    @(posedge clock);
    progImage <= img;
    reset <= 1'h1;
    repeat (2) @(posedge clock);
    reset <= 1'h0;
  endtask

  task automatic runRow(input mie_row_t r);
    int k;
    int cnt;
    int lim;
    k = 0;
    cnt = 0;
    lim = 0;
    start(r.prog);
    while (k < r.idx && lim < 100) begin
      @(posedge clock);
      #1;
      cnt++;
      lim++;
      if (instrDone === 1'h1) begin
        k++;
        if (k == r.idx) begin
          check("cycles", 12'(cnt), {9'h000, r.gap});
          check("next address", progAddr, r.pc);
          check("flags", {10'h000, flagZero, flagCarry}, {10'h000, r.flags});
        end
        cnt = 0;
      end
    end
    check("done count", 12'(k), {8'h00, r.idx});
  endtask

  task automatic haltCase(input logic [7:0] op, input logic ws, input logic [1:0] expMode);
    logic [11:0] held;
    @(posedge clock) wdogSel <= ws;
    start({8'hF9, op, 80'hF9F9_F9F9_F9F9_F9F9_F9F9});
    repeat (8) @(posedge clock);
    #1;
    check("halt mode", {10'h000, waitMode, stopMode}, {10'h000, expMode});
    held = progAddr;
    repeat (4) @(posedge clock);
    #1;
    check("halt address", progAddr, held);
    @(posedge clock) wakeUp <= 1'h1;
    @(posedge clock) wakeUp <= 1'h0;
    repeat (3) @(posedge clock);
    #1;
    check("woken mode", {10'h000, waitMode, stopMode}, 12'h000);
    $display("Halt case %h finished", op);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    reset = 1'h1;
    wdogSel = 1'h0;
    wakeUp = 1'h0;
    progImage = {12{8'hF9}};
    nMismatch = 0;
    nChecks = 0;
    repeat (12) @(posedge clock);
    #1;
    check("reset address", progAddr, 12'h000);
    check("reset state", {7'h00, waitMode, stopMode, instrDone, flagZero, flagCarry}, 12'h000);
    $display("Reset test finished");
    @(posedge clock) reset <= 1'h0;
    for (int i = 0; i < 28; i++) begin
      runRow(rows[i]);
      $display("Row %0d finished", i);
    end
    haltCase(8'hFC, 1'h0, 2'h2);
    haltCase(8'hFC, 1'h1, 2'h2);
    haltCase(8'hFD, 1'h0, 2'h1);
    haltCase(8'hFD, 1'h1, 2'h2);
    finishTest;
  end

  initial begin
    #50000;
    nMismatch++;
    $display("BAD watchdog expected finish seen hang");
    finishTest;
  end
endmodule // mcu8_instruction_execution_tb

// ==== bench/mie_core_asserts.sv ====
/*
  Port checker for the decode and execute core, bound to its top module.
  Assumes one clock domain and a synchronous active high reset.
*/
`timescale 1ns/1ps
module mie_core_asserts (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic [7:0]  progData,
  input wire logic        wdogSel,
  input wire logic        wakeUp,
  input wire logic [11:0] progAddr,
  input wire logic        waitMode,
  input wire logic        stopMode,
  input wire logic        instrDone,
  input wire logic        flagZero,
  input wire logic        flagCarry
);
  // ==========================================================
  // Opcode classes of the byte fetched in a done cycle
  // A done pulse that enters wait or stop starts no timed instruction.
  wire logic [3:0] grp     = progData[7:4];
  wire logic [3:0] lowN    = progData[3:0];
  wire logic       doneRun = instrDone && !waitMode && !stopMode;
  wire logic       shortOp = !progData[7] || (grp == 4'hF && lowN inside {4'h9, 4'hA, 4'hB});
  wire logic       stdOp   = grp inside {4'h8, 4'h9, 4'hB, 4'hC, 4'hD, 4'hE} ||
                             (grp == 4'hF && lowN <= 4'h8);

  default clocking dc @(posedge clock);
  endclocking
  default disable iff (reset);

  // ==========================================================
  // Assertions
  a_reset_clear: assert property ($fell(reset) |-> progAddr == 12'h000 && !flagZero &&
    !flagCarry && !instrDone && !waitMode && !stopMode) else $error("State not cleared by reset.");
  a_done_pulse: assert property (instrDone |=> !instrDone)
    else $error("Done pulse longer than one cycle.");
  a_short_len: assert property (
    doneRun && shortOp |-> ##1 !instrDone ##1 instrDone)
    else $error("Short instruction not two cycles.");
  a_std_len: assert property (
    doneRun && stdOp |-> ##1 !instrDone [*3] ##1 instrDone)
    else $error("Instruction not four cycles.");
  a_btest_len: assert property (
    doneRun && grp == 4'hA |-> ##1 !instrDone [*4] ##1 instrDone)
    else $error("Bit test not five cycles.");
  a_btest_zero: assert property (
    doneRun && grp == 4'hA |-> ##5 flagZero == $past(flagZero, 5))
    else $error("Bit test changed zero flag.");
  a_branch_flags: assert property (
    doneRun && !progData[7] |=> ($stable(flagZero) && $stable(flagCarry)) [*2])
    else $error("Short branch changed flags.");
  a_jump_target: assert property (doneRun && grp == 4'h8 |-> ##4
    {4'h0, progAddr} == ({$past(progData, 4), $past(progData, 3)} & 16'h0FFF))
    else $error("Bad jump target.");
  a_branch_target: assert property (doneRun && grp == 4'h0 && flagCarry |-> ##2
    progAddr == $past(progAddr, 2) + 12'($past(progData, 2) & 8'h0F) + 12'h001)
    else $error("Bad branch target.");
  a_stop_gated: assert property (wdogSel |=> !$rose(stopMode))
    else $error("Stop entered with watchdog selected.");

  // ==========================================================
  // Coverage
  c_branch: cover property (instrDone && grp == 4'h0 && flagCarry);
  c_btest: cover property (instrDone && grp == 4'hA);
  c_stop: cover property ($rose(stopMode));
  c_wait: cover property ($rose(waitMode));
endmodule // mie_core_asserts

bind mie_core mie_core_asserts mie_core_asserts_inst (
  .clock(clock), .reset(reset), .progData(progData), .wdogSel(wdogSel), .wakeUp(wakeUp),
  .progAddr(progAddr), .waitMode(waitMode), .stopMode(stopMode), .instrDone(instrDone),
  .flagZero(flagZero), .flagCarry(flagCarry));

// ==== bench/mie_prog_rom.sv ====
/*
  Program memory model: a twelve byte image at the bottom of program space.
  Assumes the core takes the byte in the same cycle as it drives the address.
*/
`timescale 1ns/1ps
module mie_prog_rom (
  input  wire logic [11:0] progAddr,
  input  wire logic [95:0] progImage,
  output logic      [7:0]  progData
);
  // Byte 0 sits in the top bits; idle opcodes fill the rest of the space.
  assign progData = (progAddr < 12'h00C) ? progImage[95 - 8 * progAddr[3:0] -: 8] : 8'hF9;
endmodule // mie_prog_rom

// ==== verilog/mie_alu.sv ====
/*
  Combinational arithmetic and logic unit of the core.
  Assumes the caller decides which flags it keeps.
*/
`timescale 1ns/1ps
module mie_alu (
  input  wire logic [3:0] op,
  input  wire logic [7:0] opA,
  input  wire logic [7:0] opB,
  input  wire logic       carryIn,
  output logic      [7:0] result,
  output logic            zeroOut,
  output logic            carryOut
);

  logic [8:0] wide;

  // ==========================================================
  // Operation select.
  always_comb begin
    wide = 9'h000;
    case (mie_pkg::mie_aluop_t'(op))
      mie_pkg::ALU_ADD: wide = {1'b0, opA} + {1'b0, opB};
      mie_pkg::ALU_AND: wide = {1'b0, opA & opB};
      mie_pkg::ALU_CP,
      mie_pkg::ALU_SUB: wide = {1'b0, opA} - {1'b0, opB};
      mie_pkg::ALU_INC: wide = {carryIn, opA + 8'h01};
      mie_pkg::ALU_DEC: wide = {carryIn, opA - 8'h01};
      mie_pkg::ALU_CLR: wide = 9'h000;
      mie_pkg::ALU_COM: wide = {opA[7], ~opA};
      mie_pkg::ALU_RLC: wide = {opA, carryIn};
      mie_pkg::ALU_SLA: wide = {opA, 1'b0};
      default:          wide = {carryIn, opA};
    endcase
  end

  assign result   = wide[7:0];
  assign carryOut = wide[8];
  assign zeroOut  = (wide[7:0] == 8'h00);

endmodule // mie_alu

// ==== verilog/mie_core.sv ====
/*
  Instruction decode and execute core: fetches opcode bytes, reads and
  writes the data space, keeps the flags, the call stack and low power.
  Assumes program memory returns the byte at progAddr in the same cycle.
*/
`timescale 1ns/1ps
module mie_core (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic [7:0]  progData,
  input  wire logic        wdogSel,
  input  wire logic        wakeUp,
  output logic      [11:0] progAddr,
  output logic             waitMode,
  output logic             stopMode,
  output logic             instrDone,
  output logic             flagZero,
  output logic             flagCarry
);

  typedef enum logic {ST_RUN, ST_HALT} mie_state_t;

  mie_state_t  state_r;
  logic [2:0]  cyc_r;
  logic [11:0] pc_r;
  logic [11:0] instrAddr_r;
  logic [7:0]  opc_r;
  logic [7:0]  b1_r;
  logic [7:0]  b2_r;
  logic [7:0]  opAddr_r;
  logic [7:0]  acc_r;
  logic        accRd_r;
  logic        zero_r;
  logic        carry_r;
  logic        zeroSh_r;
  logic        carrySh_r;
  logic        waitMode_r;
  logic        stopMode_r;
  logic        done_r;
  logic [2:0]  sp_r;
  logic [11:0] stack_r [0:mie_pkg::STACK_DEPTH-1];

  // ==========================================================
  // Decode of the current opcode.
  wire       firstCyc = (cyc_r == 3'h0);
  wire [7:0] opcNow   = firstCyc ? progData : opc_r;
  wire [3:0] hiN      = opcNow[7:4];
  wire [3:0] loN      = opcNow[3:0];
  wire       isRel    = ~opcNow[7];
  wire       isJump   = (hiN == mie_pkg::GRP_JUMP);
  wire       isCall   = (hiN == mie_pkg::GRP_CALL);
  wire       isBtst   = (hiN == mie_pkg::GRP_BTST);
  wire       isBset   = (hiN == mie_pkg::GRP_BSET);
  wire       isInd    = (hiN == mie_pkg::GRP_INDX) || (hiN == mie_pkg::GRP_INDY);
  wire       isDir    = (hiN == mie_pkg::GRP_DIR);
  wire       isSys    = (hiN == mie_pkg::GRP_SYS);
  wire       indAlu   = isInd && (loN[3:2] == 2'h0);
  wire       dirAlu   = isDir && (loN[3:2] == 2'h0);
  wire       immAlu   = isDir && (loN[3:2] == 2'h1);
  wire       aluKind  = indAlu || dirAlu || immAlu;
  wire       isCmp    = aluKind && (loN[1:0] == 2'h2);
  wire       indInc   = isInd && (loN == mie_pkg::SUB_IND_INC);
  wire       indDec   = isInd && (loN == mie_pkg::SUB_IND_DEC);
  wire       dirInc   = isDir && (loN == mie_pkg::SUB_DIR_INC);
  wire       dirDec   = isDir && (loN == mie_pkg::SUB_DIR_DEC);
  wire       accInc   = isDir && (loN == mie_pkg::SUB_ACC_INC);
  wire       accDec   = isDir && (loN == mie_pkg::SUB_ACC_DEC);
  wire       clrAcc   = isDir && (loN == mie_pkg::SUB_CLR_ACC);
  wire       clrMem   = isDir && (loN == mie_pkg::SUB_CLR_MEM);
  wire       isCom    = isDir && (loN == mie_pkg::SUB_COM);
  wire       isRlc    = isDir && (loN == mie_pkg::SUB_RLC);
  wire       sysInc   = isSys && (loN[3:2] == 2'h0);
  wire       sysDec   = isSys && (loN[3:2] == 2'h1);
  wire       isSla    = isSys && (loN == mie_pkg::SUB_SLA);
  wire       isRet    = isSys && (loN == mie_pkg::SUB_RET);
  wire       isReti   = isSys && (loN == mie_pkg::SUB_INTERRUPT_RETURN);
  wire       isWait   = isSys && (loN == mie_pkg::SUB_WAIT);
  wire       isStop   = isSys && (loN == mie_pkg::SUB_STOP);
  wire       isIncAny = indInc || dirInc || accInc || sysInc;
  wire       isDecAny = indDec || dirDec || accDec || sysDec;
  wire       sysShort = isSys && !sysInc && !sysDec && !isSla;
  wire       dirMemOp = dirAlu || dirInc || dirDec || clrMem || isBset || isBtst;
  wire       shortReg = sysInc || sysDec;

  // ==========================================================
  // Length and duration.
  wire [1:0] instrLen =
    (isBtst || clrMem)                              ? mie_pkg::LEN_THREE :
    (isRel || isInd || isCom || isRlc || sysShort
     || shortReg)                                   ? mie_pkg::LEN_ONE :
                                                      mie_pkg::LEN_TWO;
  wire [2:0] instrCyc =
    isBtst                                          ? mie_pkg::CYC_BTEST :
    (isRel || sysShort)                             ? mie_pkg::CYC_SHORT :
                                                      mie_pkg::CYC_STD;
  wire       lastCyc = (cyc_r == instrCyc - 3'h1) && (state_r == ST_RUN);
  wire       fetchB1 = (cyc_r == 3'h1) && (instrLen != mie_pkg::LEN_ONE);
  wire       fetchB2 = (cyc_r == 3'h2) && (instrLen == mie_pkg::LEN_THREE);

  // ==========================================================
  // Data space read path; the accumulator lives at the top address.
  logic [7:0] ramQ;
  wire  [7:0] idxAddr = mie_pkg::IDX_BASE | {7'h00, progData[4]};
  wire  [7:0] rdAddr  = firstCyc ? idxAddr : opAddr_r;
  wire  [7:0] rdData  = accRd_r ? acc_r : ramQ;
  wire  [7:0] shortAddr = mie_pkg::IDX_BASE | {6'h00, loN[1:0]};
  wire  [7:0] opAddrNxt =
    isInd    ? rdData :
    dirMemOp ? progData :
    shortReg ? shortAddr :
               mie_pkg::ACC_ADDR;

  // ==========================================================
  // Arithmetic unit operands and operation.
  logic [3:0] aluOp;
  logic [7:0] aluRes;
  logic       aluZero;
  logic       aluCarry;
  wire  [7:0] aluA = aluKind ? acc_r : rdData;
  wire  [7:0] aluB = immAlu ? b1_r : rdData;

  always_comb begin
    aluOp = mie_pkg::ALU_ADD;
    if (aluKind) begin
      aluOp = {2'h0, loN[1:0]};
    end else if (isIncAny) begin
      aluOp = mie_pkg::ALU_INC;
    end else if (isDecAny) begin
      aluOp = mie_pkg::ALU_DEC;
    end else if (clrAcc || clrMem) begin
      aluOp = mie_pkg::ALU_CLR;
    end else if (isCom) begin
      aluOp = mie_pkg::ALU_COM;
    end else if (isRlc) begin
      aluOp = mie_pkg::ALU_RLC;
    end else if (isSla) begin
      aluOp = mie_pkg::ALU_SLA;
    end
  end

  mie_alu mie_alu_inst (
    .op       (aluOp),
    .opA      (aluA),
    .opB      (aluB),
    .carryIn  (carry_r),
    .result   (aluRes),
    .zeroOut  (aluZero),
    .carryOut (aluCarry)
  );

  // ==========================================================
  // Single bit select, set, clear and test.
  wire [2:0] bitSel  = opc_r[3:1];
  wire       bitVal  = rdData[bitSel];
  wire [7:0] bitMask = 8'h01 << bitSel;
  wire [7:0] bitRes  = opc_r[0] ? (rdData | bitMask) : (rdData & ~bitMask);

  // ==========================================================
  // Write back.
  wire accDest = aluKind || clrAcc || isCom || isRlc || isSla;
  wire memDest = isIncAny || isDecAny || clrMem || isBset;
  wire doWrite = lastCyc && ((accDest && !isCmp) || memDest);
  wire [7:0] wrAddr = accDest ? mie_pkg::ACC_ADDR : opAddr_r;
  wire [7:0] wrData = isBset ? bitRes : aluRes;
  wire       wrAcc  = doWrite && (wrAddr == mie_pkg::ACC_ADDR);
  wire       wrRam  = doWrite && (wrAddr != mie_pkg::ACC_ADDR);
  wire updZC = aluKind || clrAcc || isCom || isRlc || isSla;
  wire updZ  = isIncAny || isDecAny;

  mie_dspace_ram mie_dspace_ram_inst (
    .clock  (clock),
    .wrEn   (wrRam),
    .wrAddr (wrAddr),
    .wrData (wrData),
    .rdAddr (rdAddr),
    .rdData (ramQ)
  );

  // ==========================================================
  // Branch conditions and targets.
  logic condMet;
  always_comb begin
    case (opc_r[7:5])
      mie_pkg::COND_C:  condMet = carry_r;
      mie_pkg::COND_NC: condMet = !carry_r;
      mie_pkg::COND_Z:  condMet = zero_r;
      mie_pkg::COND_NZ: condMet = !zero_r;
      default:          condMet = 1'b0;
    endcase
  end

  wire [11:0] span      = {8'h00, opc_r[3:0]};
  wire [11:0] relTarget = opc_r[4] ? (instrAddr_r - span)
                                   : (instrAddr_r + span + 12'h001);
  wire [11:0] btTarget  = instrAddr_r + mie_pkg::BTEST_BASE
                          + {{4{b2_r[7]}}, b2_r};
  wire        btTaken   = opc_r[0] ? bitVal : !bitVal;
  wire [11:0] extTarget = {opc_r[3:0], b1_r};
  wire [2:0]  spDown    = sp_r - 3'h1;
  wire [11:0] popAddr   = stack_r[spDown];
  wire        doPush    = lastCyc && isCall && (sp_r != mie_pkg::STACK_TOP);
  wire        doPop     = lastCyc && (isRet || isReti) && (sp_r != 3'h0);
  wire        toHalt    = lastCyc && (isWait || isStop);
  wire        stopNow   = isStop && !wdogSel;

  logic [11:0] pc_nxt;
  always_comb begin
    pc_nxt = pc_r;
    if (state_r == ST_RUN && (firstCyc || fetchB1 || fetchB2)) begin
      pc_nxt = pc_r + 12'h001;
    end
    if (lastCyc) begin
      if (isRel && condMet) begin
        pc_nxt = relTarget;
      end else if (isBtst && btTaken) begin
        pc_nxt = btTarget;
      end else if (isJump || isCall) begin
        pc_nxt = extTarget;
      end else if (isRet || isReti) begin
        pc_nxt = popAddr;
      end
    end
  end

  // ==========================================================
  // Sequencer and fetch registers.
  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= ST_RUN;
      cyc_r   <= 3'h0;
    end else if (state_r == ST_HALT) begin
      if (wakeUp) begin
        state_r <= ST_RUN;
      end
    end else if (lastCyc) begin
      cyc_r <= 3'h0;
      if (toHalt) begin
        state_r <= ST_HALT;
      end
    end else begin
      cyc_r <= cyc_r + 3'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pc_r        <= mie_pkg::PC_RESET;
      instrAddr_r <= mie_pkg::PC_RESET;
      opc_r       <= 8'h00;
      b1_r        <= 8'h00;
      b2_r        <= 8'h00;
      opAddr_r    <= mie_pkg::ACC_ADDR;
      accRd_r     <= 1'b0;
    end else begin
      pc_r    <= pc_nxt;
      accRd_r <= (rdAddr == mie_pkg::ACC_ADDR);
      if (state_r == ST_RUN && firstCyc) begin
        opc_r       <= progData;
        instrAddr_r <= pc_r;
      end
      if (fetchB1) begin
        b1_r <= progData;
      end
      if (fetchB2) begin
        b2_r <= progData;
      end
      if (cyc_r == 3'h1) begin
        opAddr_r <= opAddrNxt;
      end
    end
  end

  // ==========================================================
  // Accumulator and flags.
  always_ff @(posedge clock) begin
    if (reset) begin
      acc_r     <= 8'h00;
      zero_r    <= 1'b0;
      carry_r   <= 1'b0;
      zeroSh_r  <= 1'b0;
      carrySh_r <= 1'b0;
    end else if (lastCyc) begin
      if (wrAcc) begin
        acc_r <= wrData;
      end
      if (updZC) begin
        zero_r  <= aluZero;
        carry_r <= aluCarry;
      end else if (updZ) begin
        zero_r <= aluZero;
      end else if (isBtst) begin
        carry_r <= bitVal;
      end else if (isReti) begin
        zero_r    <= zeroSh_r;
        carry_r   <= carrySh_r;
        zeroSh_r  <= zero_r;
        carrySh_r <= carry_r;
      end
    end
  end

  // ==========================================================
  // Return address stack.
  always_ff @(posedge clock) begin
    if (reset) begin
      sp_r <= 3'h0;
    end else if (doPush) begin
      sp_r <= sp_r + 3'h1;
    end else if (doPop) begin
      sp_r <= spDown;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < mie_pkg::STACK_DEPTH; gi = gi + 1) begin : g_stack
      always_ff @(posedge clock) begin
        if (reset) begin
          stack_r[gi] <= mie_pkg::PC_RESET;
        end else if (doPush && sp_r == 3'(gi)) begin
          stack_r[gi] <= pc_r;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Low power modes and status outputs.
  always_ff @(posedge clock) begin
    if (reset) begin
      waitMode_r <= 1'b0;
      stopMode_r <= 1'b0;
      done_r     <= 1'b0;
    end else begin
      done_r <= lastCyc;
      if (state_r == ST_HALT && wakeUp) begin
        waitMode_r <= 1'b0;
        stopMode_r <= 1'b0;
      end else if (toHalt) begin
        stopMode_r <= stopNow;
        waitMode_r <= !stopNow;
      end
    end
  end

  assign progAddr  = pc_r;
  assign waitMode  = waitMode_r;
  assign stopMode  = stopMode_r;
  assign instrDone = done_r;
  assign flagZero  = zero_r;
  assign flagCarry = carry_r;

endmodule // mie_core

// ==== verilog/mie_dspace_ram.sv ====
/*
  Data space storage of 256 bytes with a registered read port.
  Assumes one read and one write per clock.
*/
`timescale 1ns/1ps
module mie_dspace_ram (
  input  wire logic       clock,
  input  wire logic       wrEn,
  input  wire logic [7:0] wrAddr,
  input  wire logic [7:0] wrData,
  input  wire logic [7:0] rdAddr,
  output logic      [7:0] rdData
);

  logic [7:0] mem [0:255];

  // ==========================================================
  // Write and registered read.
  always_ff @(posedge clock) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end

endmodule // mie_dspace_ram

// ==== verilog/mie_pkg.sv ====
/*
  Constants of the instruction decode and execute core: opcode groups,
  operand addresses, instruction lengths and cycle counts.
  Assumes a 12-bit program space and a 256-byte data space.
*/
// Summary of operation
// - ALU ops use accumulator plus memory or immediate.
// - Clear, increment, decrement reach all 256 addresses.
// - Complement, rotate, shift act on accumulator only.
// - ALU ops take 4 cycles, update Z and C.
// - Increment, decrement take 4 cycles, Z only.
// - Clear accumulator updates flags, clear memory not.
// - Complement, rotate 1 byte; shift 2 bytes.
// - Four flag branches, 1 byte, 2 cycles.
// - Short branch spans -15 to +16.
// - Bit test branch copies bit to carry.
// - Bit test displacement spans -126 to +129.
// - Bit set and clear, 2 bytes, 4 cycles.
// - Idle, return, wait, stop: 2 cycles, flags kept.
// - Interrupt return changes Z and C.
// - Stop becomes wait when watchdog selected.
// - Jump and call reach 12-bit addresses.
// - Target joins opcode low nibble and next byte.
// - Short branch: condition, direction, span fields.
// - Opcode bit 4 selects index register.
package mie_pkg;

  // ==========================================================
  // Data space addresses
  localparam logic [7:0] ACC_ADDR = 8'h00FF;
  localparam logic [7:0] IDX_BASE = 8'h0080;

  // ==========================================================
  // Opcode groups held in the high nibble
  localparam logic [3:0] GRP_JUMP = 4'h8;
  localparam logic [3:0] GRP_CALL = 4'h9;
  localparam logic [3:0] GRP_BTST = 4'hA;
  localparam logic [3:0] GRP_BSET = 4'hB;
  localparam logic [3:0] GRP_INDX = 4'hC;
  localparam logic [3:0] GRP_INDY = 4'hD;
  localparam logic [3:0] GRP_DIR  = 4'hE;
  localparam logic [3:0] GRP_SYS  = 4'hF;

  // ==========================================================
  // Low nibble codes
  localparam logic [3:0] SUB_IND_INC = 4'h4;
  localparam logic [3:0] SUB_IND_DEC = 4'h5;
  localparam logic [3:0] SUB_DIR_INC = 4'h8;
  localparam logic [3:0] SUB_DIR_DEC = 4'h9;
  localparam logic [3:0] SUB_ACC_INC = 4'hA;
  localparam logic [3:0] SUB_ACC_DEC = 4'hB;
  localparam logic [3:0] SUB_CLR_ACC = 4'hC;
  localparam logic [3:0] SUB_CLR_MEM = 4'hD;
  localparam logic [3:0] SUB_COM     = 4'hE;
  localparam logic [3:0] SUB_RLC     = 4'hF;
  localparam logic [3:0] SUB_SLA     = 4'h8;
  localparam logic [3:0] SUB_NOP     = 4'h9;
  localparam logic [3:0] SUB_RET     = 4'hA;
  localparam logic [3:0] SUB_INTERRUPT_RETURN    = 4'hB;
  localparam logic [3:0] SUB_WAIT    = 4'hC;
  localparam logic [3:0] SUB_STOP    = 4'hD;

  // ==========================================================
  // Short branch conditions in opcode bits 7:5
  localparam logic [2:0] COND_C  = 3'h0;
  localparam logic [2:0] COND_NC = 3'h1;
  localparam logic [2:0] COND_Z  = 3'h2;
  localparam logic [2:0] COND_NZ = 3'h3;

  // ==========================================================
  // Lengths, cycle counts and sizes
  localparam logic [1:0]  LEN_ONE    = 2'h1;
  localparam logic [1:0]  LEN_TWO    = 2'h2;
  localparam logic [1:0]  LEN_THREE  = 2'h3;
  localparam logic [2:0]  CYC_SHORT  = 3'h2;
  localparam logic [2:0]  CYC_STD    = 3'h4;
  localparam logic [2:0]  CYC_BTEST  = 3'h5;
  localparam logic [11:0] BTEST_BASE = 12'h002;
  localparam int          STACK_DEPTH = 6;
  localparam logic [2:0]  STACK_TOP  = 3'h6;
  localparam logic [11:0] PC_RESET   = 12'h000;

  // ==========================================================
  // Arithmetic unit operations
  typedef enum logic [3:0] {
    ALU_ADD, ALU_AND, ALU_CP, ALU_SUB, ALU_INC, ALU_DEC,
    ALU_CLR, ALU_COM, ALU_RLC, ALU_SLA
  } mie_aluop_t;

endpackage
